// file: core/fsp_pkg.sv
// Package of constants for the flash sector protection block
`default_nettype none
package fsp_pkg;
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 8;
	localparam int          SECT_BYTES    = 4096;
	localparam int          ARRAY_BYTES   = 32768;
	localparam int          MEM_AW        = 15;
	localparam logic [15:0] SECT0_BASE    = 16'hF000;
	localparam logic [15:0] SECT1_BASE    = 16'hE000;
	localparam logic [15:0] ARRAY_BASE    = 16'h8000;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [1:0]  SECT_NONE     = 2'h3;
	localparam logic [1:0]  MODE_TOOL     = 2'h0;
	localparam logic [1:0]  MODE_IN_CIRCUIT = 2'h1;
	localparam logic [1:0]  MODE_IN_APP     = 2'h2;
	localparam int          OPT_RDP_BIT   = 0;
	localparam logic [7:0]  OPT_RESET     = 8'h00;
	localparam logic [14:0] MEM_LAST      = 15'h7FFF;
	localparam logic [14:0] MEM_ZERO      = 15'h0000;
	localparam logic [14:0] MEM_ONE       = 15'h0001;
	typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_OPT} fsp_state_t;
endpackage : fsp_pkg
`default_nettype wire

// file: core/fsp_mem.sv
// Byte-wide array memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module fsp_mem (
	input  wire logic        ref_clk,  // System clock
	input  wire logic        we,       // Write strobe
	input  wire logic [14:0] waddr,    // Write address
	input  wire logic [7:0]  wdata,    // Write data
	input  wire logic [14:0] raddr,    // Read address
	output logic      [7:0]  rdata     // Registered read data
);
	logic [7:0] mem [0:32767];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : fsp_mem
`default_nettype wire

// file: core/fsp_top.sv
// Flash sector map, program/erase engine and read-out protection
//
// Behaviour
// RULE1: Erase works on the whole array or one sector, programming works one byte at a time.
// RULE2: A sector erase or program only writes bytes inside the addressed sector.
// RULE3: In tool and in-circuit modes every sector and the option byte may be changed.
// RULE4: In in-application mode sector 0 cannot be programmed or erased.
// RULE5: The sector count is one for 4K, two for 8K and three for larger arrays.
// RULE6: Sectors 0 and 1 are 4 Kbytes each at the top, the rest of the array is sector 2.
// RULE7: Sector 0 decodes to F000h through FFFFh and holds the vectors.
// RULE8: With read-out protection set, external reads return erased data and writes are refused.
// RULE9: Clearing the protection option first erases the whole array, then updates the option.
// RULE10: One dedicated option bit turns read-out protection on and off.
// RULE11: An 8-bit control and status byte resets to zero and is held for tool software.
// RULE12: Requests to a protected sector or under read-out protection are ignored; the code still takes option byte writes under protection.
`timescale 1ns/1ps
`default_nettype none
module fsp_top #(
	parameter int ARRAY_SIZE = fsp_pkg::ARRAY_BYTES  // Array bytes: 4096, 8192 or up to 32768
) (
	input  wire logic        ref_clk,       // 50 MHz system clock
	input  wire logic        rst_b,         // Asynchronous reset, active low
	input  wire logic [1:0]  prog_mode,     // 0 tool, 1 in-circuit, 2 in-application
	input  wire logic        ext_access,    // Read comes from an external tool
	input  wire logic [15:0] rd_addr,       // Read address
	output logic      [7:0]  rd_data,       // Read data
	output logic      [1:0]  rd_sector,     // Sector of read address, 3 if unmapped
	input  wire logic        prog_req,      // Program one byte
	input  wire logic        sect_erase_req,// Erase sector of wr_addr
	input  wire logic        full_erase_req,// Erase whole array
	input  wire logic [15:0] wr_addr,       // Program or erase address
	input  wire logic [7:0]  wr_data,       // Program data
	input  wire logic        opt_wr_req,    // Write option byte
	input  wire logic [7:0]  opt_wr_data,   // New option byte
	output logic      [7:0]  opt_byte,      // Current option byte
	output logic             readout_protect_option, // Protection active
	input  wire logic        ctrl_wr,       // Write control/status byte
	input  wire logic [7:0]  ctrl_wdata,    // Control/status write data
	output logic      [7:0]  flash_ctrl_status, // Control/status byte
	output logic             busy,          // Engine erasing
	output logic             req_refused    // Last request was ignored
);
	// ----------------------------------------------------------------
	// Sector map
	// ----------------------------------------------------------------
	logic [15:0] array_lo;
	logic [1:0]  sect_cnt;

	// RULE5: sectors follow size
	assign sect_cnt = (ARRAY_SIZE <= fsp_pkg::SECT_BYTES) ? 2'h1 :
	                  (ARRAY_SIZE <= 2 * fsp_pkg::SECT_BYTES) ? 2'h2 : 2'h3;
	assign array_lo = 16'(17'h10000 - 17'(ARRAY_SIZE));

	function automatic logic [1:0] sect_of(input logic [15:0] a, input logic [1:0] n);
		logic [1:0] s;
		s = fsp_pkg::SECT_NONE;
		// RULE7: top 4K is sector 0
		if (a >= fsp_pkg::SECT0_BASE) begin
			s = 2'h0;
		// RULE6: fixed 4K sector 1, rest sector 2
		end else if (a >= fsp_pkg::SECT1_BASE) begin
			s = (n >= 2'h2) ? 2'h1 : fsp_pkg::SECT_NONE;
		end else if (n == 2'h3) begin
			s = 2'h2;
		end
		return s;
	endfunction : sect_of

	logic [1:0] wr_sect;
	logic [1:0] rd_sect_raw;
	assign wr_sect     = sect_of(wr_addr, sect_cnt);
	assign rd_sect_raw = sect_of(rd_addr, sect_cnt);
	assign rd_sector   = (rd_addr >= array_lo) ? rd_sect_raw : fsp_pkg::SECT_NONE;

	// ----------------------------------------------------------------
	// Option byte and control byte
	// ----------------------------------------------------------------
	logic [7:0] opt_ff;
	logic [7:0] opt_pend_ff;
	logic [7:0] ctrl_ff;
	logic       rdp;

	// RULE10: single protection bit
	assign rdp = opt_ff[fsp_pkg::OPT_RDP_BIT];
	assign opt_byte = opt_ff;
	assign readout_protect_option = rdp;

	// RULE11: control byte resets to zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= fsp_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_ff <= ctrl_wdata;
		end
	end
	assign flash_ctrl_status = ctrl_ff;

	// ----------------------------------------------------------------
	// Request checking
	// ----------------------------------------------------------------
	logic in_app;
	logic sect_ok;
	logic do_prog;
	logic do_serase;
	logic do_ferase;
	logic do_opt;
	logic opt_unprotect;
	fsp_pkg::fsp_state_t state_ff;
	logic idle;

	assign idle = (state_ff == fsp_pkg::FSP_IDLE);
	assign in_app = (prog_mode == fsp_pkg::MODE_IN_APP);
	// RULE3: tool and in-circuit reach all sectors
	// RULE4: sector 0 locked in application mode
	assign sect_ok = (wr_sect != fsp_pkg::SECT_NONE) && (wr_addr >= array_lo) &&
	                 !(in_app && (wr_sect == 2'h0));
	// RULE8: writes refused under protection
	// RULE12: bad requests ignored
	assign do_prog   = idle && prog_req && sect_ok && !rdp;
	assign do_serase = idle && sect_erase_req && sect_ok && !rdp;
	assign do_ferase = idle && full_erase_req && !in_app && !rdp;
	assign do_opt    = idle && opt_wr_req && !in_app;
	assign opt_unprotect = do_opt && rdp && !opt_wr_data[fsp_pkg::OPT_RDP_BIT];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_refused <= 1'b0;
		end else if (idle && (prog_req || sect_erase_req || full_erase_req || opt_wr_req)) begin
			req_refused <= !(do_prog || do_serase || do_ferase || do_opt);
		end
	end

	// ----------------------------------------------------------------
	// Erase engine
	// ----------------------------------------------------------------
	logic [14:0] ptr_ff;
	logic [14:0] end_ff;
	logic [14:0] mem_wa;
	logic [7:0]  mem_wd;
	logic        mem_we;
	logic [14:0] lo_idx;
	logic [15:0] sect_lo;
	logic [15:0] sect_hi;

	assign lo_idx = array_lo[14:0];
	always_comb begin
		sect_lo = array_lo;
		sect_hi = fsp_pkg::SECT1_BASE - 16'h0001;
		if (wr_sect == 2'h0) begin
			sect_lo = fsp_pkg::SECT0_BASE;
			sect_hi = 16'hFFFF;
		end else if (wr_sect == 2'h1) begin
			sect_lo = fsp_pkg::SECT1_BASE;
			sect_hi = fsp_pkg::SECT0_BASE - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= fsp_pkg::FSP_IDLE;
			ptr_ff   <= fsp_pkg::MEM_ZERO;
			end_ff   <= fsp_pkg::MEM_ZERO;
		end else begin
			case (state_ff)
				fsp_pkg::FSP_IDLE: begin
					// RULE9: erase before unprotect
					if (opt_unprotect || do_ferase) begin
						// RULE1: whole array erase
						state_ff <= opt_unprotect ? fsp_pkg::FSP_OPT : fsp_pkg::FSP_ERASE;
						ptr_ff   <= lo_idx;
						end_ff   <= fsp_pkg::MEM_LAST;
					end else if (do_serase) begin
						// RULE2: bounds kept to one sector
						state_ff <= fsp_pkg::FSP_ERASE;
						ptr_ff   <= sect_lo[14:0];
						end_ff   <= sect_hi[14:0];
					end
				end
				fsp_pkg::FSP_ERASE, fsp_pkg::FSP_OPT: begin
					ptr_ff <= ptr_ff + fsp_pkg::MEM_ONE;
					if (ptr_ff == end_ff) begin
						state_ff <= fsp_pkg::FSP_IDLE;
					end
				end
				default: state_ff <= fsp_pkg::FSP_IDLE;
			endcase
		end
	end
	assign busy = !idle;

	// A protection-clearing option write takes effect only after the erase has swept the array
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			opt_ff      <= fsp_pkg::OPT_RESET;
			opt_pend_ff <= fsp_pkg::OPT_RESET;
		end else if (opt_unprotect) begin
			opt_pend_ff <= opt_wr_data;
		end else if (do_opt) begin
			opt_ff <= opt_wr_data;
		end else if ((state_ff == fsp_pkg::FSP_OPT) && (ptr_ff == end_ff)) begin
			// RULE9: option applied after erase
			opt_ff <= opt_pend_ff;
		end
	end

	// RULE1: byte-wise program path
	assign mem_we = do_prog || !idle;
	assign mem_wa = idle ? wr_addr[14:0] : ptr_ff;
	assign mem_wd = idle ? wr_data : fsp_pkg::ERASED_BYTE;

	// ----------------------------------------------------------------
	// Array and read path
	// ----------------------------------------------------------------
	logic [7:0] mem_rd;
	logic       hide_ff;

	fsp_mem u_mem (
		.ref_clk (ref_clk),
		.we      (mem_we),
		.waddr   (mem_wa),
		.wdata   (mem_wd),
		.raddr   (rd_addr[14:0]),
		.rdata   (mem_rd)
	);

	// RULE8: block external extraction
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hide_ff <= 1'b1;
		end else begin
			hide_ff <= (rdp && ext_access) || (rd_addr < array_lo);
		end
	end
	assign rd_data = hide_ff ? fsp_pkg::ERASED_BYTE : mem_rd;
endmodule : fsp_top
`default_nettype wire

// file: tb/fsp_chk.sv
// Port checker for the flash sector protection block
`timescale 1ns/1ps
`default_nettype none
module fsp_chk (
	input wire logic        ref_clk,      // Clock
	input wire logic        rst_b,        // Reset
	input wire logic [1:0]  prog_mode,    // Mode
	input wire logic        ext_access,   // External read
	input wire logic [15:0] rd_addr,      // Read address
	input wire logic [7:0]  rd_data,      // Read data
	input wire logic [1:0]  rd_sector,    // Read sector
	input wire logic        prog_req,     // Program
	input wire logic        full_erase_req, // Array erase
	input wire logic [15:0] wr_addr,      // Target
	input wire logic        opt_wr_req,   // Option write
	input wire logic [7:0]  opt_wr_data,  // Option data
	input wire logic        readout_protect_option, // Protected
	input wire logic        busy,         // Erasing
	input wire logic        req_refused   // Ignored
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ----
	// Sequences
	// ----
	sequence idle_in_app;
		!busy && prog_mode == fsp_pkg::MODE_IN_APP;
	endsequence
	sequence unprot_req;
		!busy && opt_wr_req && !opt_wr_data[0] && readout_protect_option
			&& prog_mode != fsp_pkg::MODE_IN_APP;
	endsequence
	erase_start_a: assert property (
		!busy && full_erase_req && !readout_protect_option && prog_mode != fsp_pkg::MODE_IN_APP
		|=> busy) else $error("erase did not start");
	app_full_a: assert property (
		idle_in_app ##0 full_erase_req |=> !busy && req_refused)
		else $error("application mode erase taken");
	app_sect0_a: assert property (
		idle_in_app ##0 prog_req && wr_addr[15:12] == 4'hF |=> req_refused)
		else $error("application mode sector 0 write taken");
	rdp_prog_a: assert property (
		!busy && prog_req && readout_protect_option |=> req_refused)
		else $error("protected write taken");
	sect0_dec_a: assert property (
		rd_addr[15:12] == 4'hF |-> rd_sector == 2'h0) else $error("sector 0 decode");
	sect1_dec_a: assert property (
		rd_addr[15:12] == 4'hE |-> rd_sector == 2'h1) else $error("sector 1 decode");
	ext_read_a: assert property (
		readout_protect_option && ext_access ##1 readout_protect_option && ext_access
		|-> rd_data == 8'hFF) else $error("protected data leaked");
	unprot_erase_a: assert property (
		unprot_req |=> busy && readout_protect_option) else $error("no erase before unprotect");
endmodule : fsp_chk
bind fsp_top fsp_chk u_chk (.ref_clk, .rst_b, .prog_mode, .ext_access, .rd_addr, .rd_data,
	.rd_sector, .prog_req, .full_erase_req, .wr_addr, .opt_wr_req, .opt_wr_data,
	.readout_protect_option, .busy, .req_refused);
`default_nettype wire

// file: tb/fsp_tool.sv
// Programming tool model, one request at a time
`timescale 1ns/1ps
`default_nettype none
module fsp_tool (
	input  wire logic        ref_clk, // Clock
	input  wire logic        busy,    // Engine erasing
	output var  logic [3:0]  req,     // Option, array, sector, program
	output var  logic [15:0] wr_addr, // Target
	output var  logic [7:0]  wr_data  // Byte or option data
);
	initial {req, wr_addr, wr_data} = 28'h0;
	// Kind 0 program, 1 sector, 2 array, 3 option
	task op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= 4'h1 << k;
		wr_addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		req <= 4'h0;
		// Released lines must not show the old value
		wr_addr <= ~a;
		wr_data <= ~d;
		#1;
		while (busy) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : op
endmodule : fsp_tool
`default_nettype wire

// file: tb/flash_sector_protection_tb_top.sv
// Self-checking bench for the flash sector protection block
`timescale 1ns/1ps
`default_nettype none
module flash_sector_protection_tb_top;
	localparam int AS = 16384;
	localparam logic [15:0] BASE = 16'(65536 - AS);
	logic ref_clk, rst_b, ext_access, ctrl_wr, busy, readout_protect_option, req_refused;
	logic [1:0] prog_mode, rd_sector;
	logic [3:0] req;
	logic [15:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data, opt_byte, ctrl_wdata, flash_ctrl_status;
	logic [7:0] mem_m [0:AS-1];
	logic [15:0] aq[$];
	logic [15:0] tab [8] = '{16'hFFFF, 16'hF000, 16'hEFFF, 16'hE000, 16'hDFFF, 16'hC000,
		16'hBFFF, 16'h0000};
	int mismatches, checks_done, cycles, seed;
	fsp_top #(.ARRAY_SIZE(AS)) u_dut (.ref_clk, .rst_b, .prog_mode, .ext_access, .rd_addr,
		.rd_data, .rd_sector, .prog_req(req[0]), .sect_erase_req(req[1]),
		.full_erase_req(req[2]), .wr_addr, .wr_data, .opt_wr_req(req[3]),
		.opt_wr_data(wr_data), .opt_byte, .readout_protect_option, .ctrl_wr, .ctrl_wdata,
		.flash_ctrl_status, .busy, .req_refused);
	fsp_tool u_tool (.ref_clk, .busy, .req, .wr_addr, .wr_data);
	// ----
	// Helpers
	// ----
	function automatic logic [1:0] sect_of(input logic [15:0] a);
		if (a >= 16'hF000) return 2'h0;
		if (a >= 16'hE000) return 2'h1;
		return (a >= BASE) ? 2'h2 : 2'h3;
	endfunction : sect_of
	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : check
	task test_done;
		if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	task fill(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) mem_m[i - int'(BASE)] = 8'hFF;
	endtask : fill
	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		rd_addr <= a;
		@(posedge ref_clk);
		#1 v = rd_data;
	endtask : rd
	task vfy;
		logic [7:0] v;
		foreach (aq[i]) begin
			rd(aq[i], v);
			check(v, mem_m[aq[i] - BASE]);
		end
	endtask : vfy
	task prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
		u_tool.op(2'h0, a, d);
		check({7'h0, req_refused}, {7'h0, !ok});
		if (ok) mem_m[a - BASE] = d;
	endtask : prog
	task mode(input logic [1:0] m);
		@(posedge ref_clk);
		prog_mode <= m;
	endtask : mode
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the three sweeps
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		logic [15:0] a;
		logic [7:0] v;
		seed = 32'hF134;
		{rst_b, ext_access, ctrl_wr, prog_mode, rd_addr, ctrl_wdata} = 29'h0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1 check(flash_ctrl_status, 8'h00);
		@(posedge ref_clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= 8'hA5;
		@(posedge ref_clk);
		ctrl_wr <= 1'b0;
		#1 check(flash_ctrl_status, 8'hA5);
		u_tool.op(2'h2, 16'h0000, 8'h00);
		fill(int'(BASE), 65535);
		foreach (tab[i]) begin
			@(posedge ref_clk);
			rd_addr <= tab[i];
			#1 check({6'h0, rd_sector}, {6'h0, sect_of(tab[i])});
		end
		for (int i = 0; i < 30; i++) begin
			a = (i < 6) ? tab[i] : BASE + 16'($unsigned($random(seed)) % AS);
			if (mem_m[a - BASE] !== 8'hFF) continue;
			prog(a, 8'($random(seed)), 1'b1);
			aq.push_back(a);
		end
		vfy();
		u_tool.op(2'h1, 16'hE123, 8'h00);
		fill(32'hE000, 32'hEFFF);
		vfy();
		mode(fsp_pkg::MODE_IN_APP);
		prog(16'hF000, 8'h12, 1'b0);
		prog(16'hE000, 8'h34, 1'b1);
		for (int k = 1; k < 4; k++) begin
			u_tool.op(2'(k), 16'hF800, 8'h01);
			check({7'h0, req_refused}, 8'h01);
		end
		check(opt_byte, 8'h00);
		vfy();
		mode(fsp_pkg::MODE_TOOL);
		u_tool.op(2'h3, 16'h0000, 8'h01);
		check({7'h0, readout_protect_option}, 8'h01);
		prog(16'hC000, 8'h00, 1'b0);
		@(posedge ref_clk);
		ext_access <= 1'b1;
		rd(16'hF000, v);
		check(v, 8'hFF);
		@(posedge ref_clk);
		ext_access <= 1'b0;
		u_tool.op(2'h3, 16'h0000, 8'h00);
		check(opt_byte, 8'h00);
		fill(int'(BASE), 65535);
		vfy();
		mode(fsp_pkg::MODE_IN_CIRCUIT);
		prog(16'hF001, 8'h5A, 1'b1);
		rd(16'hF001, v);
		check(v, 8'h5A);
		test_done();
	end
endmodule : flash_sector_protection_tb_top
`default_nettype wire
